// ### logic/icp_timer.sv
/*
  Eight-bit compare timer with PWM mode and infrared carrier generator mode.
  Registers are reached over a plain port with one-cycle strobes and read
  data in the following cycle. The partner timer event input is taken as
  synchronous to clk_in and is re-timed onto the selected count clock.
*/
// The implementer's own choices: the plain strobed port and the address map.
// Contract
// - PWM start swallows one count clock, output held inactive meanwhile.
// - Duty writes while running are latched; transfer only on old duty match.
// - Latched duty transfers only after three count clocks since the write.
// - PWM period match clears counter, drives output active, raises interrupt.
// - PWM duty match drives output inactive, no clear, no interrupt.
// - Clearing run drops the interrupt and forces PWM output inactive.
// - Carrier mode: low-width compare sets low time, high-width sets high time.
// - Output low, high, or carrier per level bit and remote enable.
// - Output level uses staging bit (read/write) and read-only active bit.
// - Partner event is re-timed to the count clock as a transfer strobe.
// - Staging copies to active on second count clock after strobe rise.
// - Carrier starts with low-width compare; each match clears, interrupts, alternates.
// - Carrier appears on the output pin only while the active bit is high.
// - Carrier period is N+M+2 count clocks, high time M+1.
// - New high-width value takes effect only after three count clocks.
// - Active bit falling mid high phase keeps output high until phase ends.
module icp_timer import icp_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter bit CARRIER_EN = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  // Partner timer
  input wire logic partner_timer_event_in,
  // Timer results
  output logic timer_output_out,
  output logic compare_match_irq_out,
  output logic synced_transfer_strobe_out
);

  logic [7:0] ctrl_r;
  logic [7:0] period_compare_r;
  logic [7:0] duty_compare_r;
  logic [7:0] duty_latch_r;
  logic duty_pend_r;
  logic [1:0] duty_age_r;
  logic output_level_staging_r;
  logic output_level_active_r;
  logic remote_output_enable_r;
  logic [ICP_PRESC_W-1:0] presc_r;
  logic cnt_en_r;
  logic [7:0] counter_r;
  logic [7:0] counter_nxt;
  logic sel_r;
  logic sel_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic started_r;
  logic started_nxt;
  logic irq_nxt;
  logic xfer_now;
  logic out_nxt;
  logic evt_prev_r;
  logic evt_pend_r;
  logic [1:0] xfer_sh_r;
  logic [DATA_W-1:0] rdata_r;
  logic run;
  logic carrier;
  logic [ICP_CKSEL_W-1:0] cksel;
  logic [ICP_PRESC_W-1:0] presc_mask;
  logic wr_cmp1;

  assign run = ctrl_r[ICP_CTRL_RUN_BIT];
  assign carrier = ctrl_r[ICP_CTRL_CARRIER_BIT] & CARRIER_EN;
  assign cksel = ctrl_r[ICP_CTRL_CKSEL_LSB +: ICP_CKSEL_W];
  assign wr_cmp1 = wr_in && (addr_in == ADDR_W'(ICP_OFS_CMP1));

  ////////////////////////////////////////////////////////////////////////
  // Count clock: one-cycle enable every 2**cksel system clocks
  assign presc_mask = ICP_PRESC_W'((8'h01 << cksel) - 8'h01);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_r <= '0;
      cnt_en_r <= 1'b0;
    end else begin
      presc_r <= presc_r + ICP_PRESC_W'(1);
      cnt_en_r <= ((presc_r & presc_mask) == presc_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= ICP_CTRL_RESET;
      period_compare_r <= ICP_CMP0_RESET;
      output_level_staging_r <= 1'b0;
      remote_output_enable_r <= 1'b0;
    end else if (wr_in) begin
      unique case (addr_in)
        ADDR_W'(ICP_OFS_CTRL): ctrl_r <= wdata_in[7:0];
        ADDR_W'(ICP_OFS_CMP0): period_compare_r <= wdata_in[7:0];
        ADDR_W'(ICP_OFS_CARRIER_CTRL): begin
          output_level_staging_r <= wdata_in[ICP_CC_STAGING_BIT];
          remote_output_enable_r <= wdata_in[ICP_CC_REMOTE_BIT];
        end
        default: ;
      endcase
    end
  end

  // Duty or high-width compare with write latch and age counter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      duty_compare_r <= ICP_CMP1_RESET;
      duty_latch_r <= ICP_CMP1_RESET;
      duty_pend_r <= 1'b0;
      duty_age_r <= 2'h0;
    end else if (wr_cmp1) begin
      duty_latch_r <= wdata_in[7:0];
      duty_age_r <= 2'h0;
      duty_pend_r <= run;
      if (!run) begin
        duty_compare_r <= wdata_in[7:0];
      end
    end else if (xfer_now) begin
      duty_compare_r <= duty_latch_r;
      duty_pend_r <= 1'b0;
    end else if (cnt_en_r && duty_pend_r && duty_age_r != ICP_CMP1_AGE) begin
      duty_age_r <= duty_age_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, compare select and waveform level
  always_comb begin
    counter_nxt = counter_r;
    sel_nxt = sel_r;
    lvl_nxt = lvl_r;
    started_nxt = started_r;
    irq_nxt = 1'b0;
    xfer_now = 1'b0;
    if (!run) begin
      counter_nxt = 8'h00;
      sel_nxt = 1'b0;
      lvl_nxt = 1'b0;
      started_nxt = 1'b0;
    end else if (cnt_en_r) begin
      if (carrier) begin
        if (counter_r == (sel_r ? duty_compare_r : period_compare_r)) begin
          counter_nxt = 8'h00;
          sel_nxt = ~sel_r;
          lvl_nxt = ~lvl_r;
          irq_nxt = 1'b1;
          xfer_now = sel_r && duty_pend_r && duty_age_r == ICP_CMP1_AGE;
        end else begin
          counter_nxt = counter_r + 8'h01;
        end
      end else if (!started_r) begin
        started_nxt = 1'b1;
      end else if (!sel_r && counter_r == period_compare_r) begin
        counter_nxt = 8'h00;
        sel_nxt = 1'b1;
        lvl_nxt = 1'b1;
        irq_nxt = 1'b1;
      end else begin
        counter_nxt = counter_r + 8'h01;
        if (sel_r && counter_r == duty_compare_r) begin
          sel_nxt = 1'b0;
          lvl_nxt = 1'b0;
          xfer_now = duty_pend_r && duty_age_r == ICP_CMP1_AGE;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      counter_r <= 8'h00;
      sel_r <= 1'b0;
      lvl_r <= 1'b0;
      started_r <= 1'b0;
      compare_match_irq_out <= 1'b0;
    end else begin
      counter_r <= counter_nxt;
      sel_r <= sel_nxt;
      lvl_r <= lvl_nxt;
      started_r <= started_nxt;
      compare_match_irq_out <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Partner event re-timing and staging to active transfer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      evt_prev_r <= 1'b0;
      evt_pend_r <= 1'b0;
      synced_transfer_strobe_out <= 1'b0;
      xfer_sh_r <= 2'h0;
      output_level_active_r <= 1'b0;
    end else begin
      evt_prev_r <= partner_timer_event_in;
      if (partner_timer_event_in && !evt_prev_r) begin
        evt_pend_r <= 1'b1;
      end else if (cnt_en_r) begin
        evt_pend_r <= 1'b0;
      end
      if (cnt_en_r) begin
        synced_transfer_strobe_out <= evt_pend_r;
        xfer_sh_r <= {xfer_sh_r[0], evt_pend_r & ~synced_transfer_strobe_out};
        if (xfer_sh_r[1]) begin
          output_level_active_r <= output_level_staging_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pin
  always_comb begin
    if (!carrier) begin
      out_nxt = lvl_nxt;
    end else if (output_level_active_r) begin
      out_nxt = remote_output_enable_r ? lvl_nxt : 1'b1;
    end else begin
      out_nxt = timer_output_out & remote_output_enable_r & lvl_r & lvl_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_output_out <= 1'b0;
    end else begin
      timer_output_out <= out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (rd_in) begin
        unique case (addr_in)
          ADDR_W'(ICP_OFS_CTRL): rdata_r <= DATA_W'(ctrl_r);
          ADDR_W'(ICP_OFS_CMP0): rdata_r <= DATA_W'(period_compare_r);
          ADDR_W'(ICP_OFS_CMP1): rdata_r <= DATA_W'(duty_pend_r ? duty_latch_r : duty_compare_r);
          ADDR_W'(ICP_OFS_CARRIER_CTRL): begin
            rdata_r[ICP_CC_STAGING_BIT] <= output_level_staging_r;
            rdata_r[ICP_CC_ACTIVE_BIT] <= output_level_active_r;
            rdata_r[ICP_CC_REMOTE_BIT] <= remote_output_enable_r;
          end
          ADDR_W'(ICP_OFS_STATUS): begin
            rdata_r[ICP_ST_COUNT_LSB +: 8] <= counter_r;
            rdata_r[ICP_ST_OUT_BIT] <= timer_output_out;
            rdata_r[ICP_ST_PEND_BIT] <= duty_pend_r;
          end
          default: ;
        endcase
      end
    end
  end

  assign rdata_out = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_pwm_swallow: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_en_r && run && !carrier && !started_r && !wr_in) |=> (counter_r == 8'h00 && !timer_output_out))
    else $error("PWM start did not swallow a count clock");

  chk_duty_early_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_en_r && run && !carrier && started_r && sel_r && counter_r == duty_compare_r
     && duty_age_r != ICP_CMP1_AGE && !wr_cmp1) |=> duty_compare_r == $past(duty_compare_r))
    else $error("Duty value transferred too early");

  chk_period_match: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_en_r && run && !carrier && started_r && !sel_r && counter_r == period_compare_r && !wr_in)
    |=> (counter_r == 8'h00 && timer_output_out && compare_match_irq_out))
    else $error("Period match effects missing");

  chk_duty_match: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_en_r && run && !carrier && started_r && sel_r && counter_r == duty_compare_r && !wr_in)
    |=> (!timer_output_out && !compare_match_irq_out && counter_r == $past(counter_r) + 8'h01))
    else $error("Duty match effects wrong");

  chk_stop_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    (!run && !carrier) |=> (!compare_match_irq_out && !timer_output_out))
    else $error("Stopped timer still active");

  chk_strobe_retime: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_en_r && evt_pend_r) |=> synced_transfer_strobe_out)
    else $error("Pending event not turned into a transfer strobe");

  chk_active_load: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_en_r && xfer_sh_r[1]) |=> output_level_active_r == $past(output_level_staging_r))
    else $error("Active bit not loaded from staging");

  chk_carrier_alt: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_en_r && run && carrier && counter_r == (sel_r ? duty_compare_r : period_compare_r) && !wr_in)
    |=> (sel_r != $past(sel_r) && counter_r == 8'h00 && compare_match_irq_out))
    else $error("Carrier match did not alternate");

  chk_carrier_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    (carrier && !output_level_active_r && !timer_output_out) |=> !timer_output_out)
    else $error("Carrier leaked with active bit low");

  chk_high_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (carrier && $fell(output_level_active_r) && timer_output_out && remote_output_enable_r && lvl_r && lvl_nxt)
    |=> timer_output_out)
    else $error("Carrier high phase cut short");

endmodule : icp_timer

// ### logic/icp_pkg.sv
/*
  Shared constants for the infrared carrier and PWM compare timer:
  register offsets, field positions, reset values and timing counts.
  Assumes a single 25 MHz system clock and a word-per-register plain port.
*/
package icp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] ICP_OFS_CTRL = 8'h00;
  localparam logic [7:0] ICP_OFS_CMP0 = 8'h04;
  localparam logic [7:0] ICP_OFS_CMP1 = 8'h08;
  localparam logic [7:0] ICP_OFS_CARRIER_CTRL = 8'h0c;
  localparam logic [7:0] ICP_OFS_STATUS = 8'h10;

  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int ICP_CTRL_RUN_BIT = 0;
  localparam int ICP_CTRL_CARRIER_BIT = 1;
  localparam int ICP_CTRL_CKSEL_LSB = 2;
  localparam int ICP_CKSEL_W = 3;
  localparam logic [7:0] ICP_CTRL_RESET = 8'h00;

  // Carrier control register fields
  localparam int ICP_CC_STAGING_BIT = 0;
  localparam int ICP_CC_ACTIVE_BIT = 1;
  localparam int ICP_CC_REMOTE_BIT = 2;

  // Status register fields
  localparam int ICP_ST_COUNT_LSB = 0;
  localparam int ICP_ST_OUT_BIT = 8;
  localparam int ICP_ST_PEND_BIT = 9;

  ////////////////////////////////////////////////////////////////////////
  // Compare reset values
  localparam logic [7:0] ICP_CMP0_RESET = 8'h00;
  localparam logic [7:0] ICP_CMP1_RESET = 8'h00;

  // Count clocks a new duty or high-width value must age before transfer
  localparam logic [1:0] ICP_CMP1_AGE = 2'h3;

  // Prescaler width for the count clock select
  localparam int ICP_PRESC_W = 7;

endpackage : icp_pkg

// ### bench/icp_partner.sv
/*
  Partner event timer model: counts on a divided clock and pulses one event
  per compare match. Assumes the bench starts it after the timer is set up.
*/
module icp_partner #(
  parameter int DIV = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  input wire logic [7:0] compare_in,
  // Event
  output logic event_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] div_r;
  logic [7:0] count_r;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= 8'h00;
      count_r <= 8'h00;
      event_out <= 1'b0;
    end else begin
      event_out <= 1'b0;
      if (!run_in) begin
        div_r <= 8'h00;
        count_r <= 8'h00;
      end else if (div_r == 8'(DIV - 1)) begin
        div_r <= 8'h00;
        count_r <= (count_r == compare_in) ? 8'h00 : count_r + 8'h01;
        event_out <= (count_r == compare_in);
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end
endmodule : icp_partner

// ### bench/icp_timer_test.sv
/*
  Self-checking bench for the carrier and PWM compare timer.
  Assumes a 25 MHz clock, count clock select 0 and the partner model.
*/
module icp_timer_test import icp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in, rst_in, wr, rd, prun, ev, tout, irq, stb;
  logic [7:0] addr, pcmp;
  logic [15:0] wdata, rdata;
  int miscompares = 0;
  int total_checks = 0;

  icp_timer i_icp_timer (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .partner_timer_event_in(ev),
    .timer_output_out(tout), .compare_match_irq_out(irq), .synced_transfer_strobe_out(stb));
  icp_partner i_icp_partner (.clk_in(clk_in), .rst_in(rst_in), .run_in(prun),
    .compare_in(pcmp), .event_out(ev));

  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  // Cycles spent until the output reaches level v
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (tout !== v && n < 600) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask : wait_lvl

  task automatic meas(output int hi, output int per);
    int n, lo;
    // Let the edge settle before the first look at the pin
    #1;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    per = hi + lo;
  endtask : meas

  task automatic cnt_irq(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_in);
      #1;
      if (irq === 1'b1) n++;
    end
  endtask : cnt_irq

  task automatic wait_stb();
    int n;
    n = 0;
    while (stb !== 1'b1 && n < 400) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check({15'h0, stb}, 16'h0001);
    repeat (30) @(posedge clk_in);
    #1;
  endtask : wait_stb

  task automatic hold_lvl(input logic v);
    repeat (20) begin
      @(posedge clk_in);
      #1;
      check({15'h0, tout}, {15'h0, v});
    end
  endtask : hold_lvl

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int hi, per, n;
    rst_in = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    prun = 1'b0;
    pcmp = 8'h09;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(ICP_OFS_CTRL, 16'h0000);
    rd_chk(ICP_OFS_CMP0, 16'h0000);
    rd_chk(ICP_OFS_CMP1, 16'h0000);
    rd_chk(ICP_OFS_CARRIER_CTRL, 16'h0000);
    rd_chk(ICP_OFS_STATUS, 16'h0000);
    reg_wr(8'h14, 16'h00ff);
    rd_chk(8'h14, 16'h0000);
    // PWM, period 4, duty 1
    reg_wr(ICP_OFS_CMP0, 16'h0004);
    reg_wr(ICP_OFS_CMP1, 16'h0001);
    reg_wr(ICP_OFS_CTRL, 16'h0001);
    repeat (5) begin
      @(posedge clk_in);
      #1;
      check({15'h0, tout}, 16'h0000);
    end
    meas(hi, per);
    check(16'(hi), 16'd2);
    check(16'(per), 16'd5);
    cnt_irq(50, n);
    check(16'(n), 16'd10);
    reg_wr(ICP_OFS_CMP1, 16'h0003);
    rd_chk(ICP_OFS_CMP1, 16'h0003);
    rd_chk(ICP_OFS_STATUS, 16'h0300);
    repeat (12) @(posedge clk_in);
    meas(hi, per);
    check(16'(hi), 16'd4);
    check(16'(per), 16'd5);
    // Stop mid-run
    reg_wr(ICP_OFS_CTRL, 16'h0000);
    repeat (3) begin
      @(posedge clk_in);
      #1;
      check({14'h0, tout, irq}, 16'h0000);
    end
    rd_chk(ICP_OFS_STATUS, 16'h0000);
    // Carrier, low width 3, high width 2
    reg_wr(ICP_OFS_CMP0, 16'h0003);
    reg_wr(ICP_OFS_CMP1, 16'h0002);
    reg_wr(ICP_OFS_CARRIER_CTRL, 16'h0005);
    reg_wr(ICP_OFS_CTRL, 16'h0003);
    prun <= 1'b1;
    wait_stb();
    rd_chk(ICP_OFS_CARRIER_CTRL, 16'h0007);
    meas(hi, per);
    check(16'(hi), 16'd3);
    check(16'(per), 16'd7);
    cnt_irq(70, n);
    check(16'(n), 16'd20);
    reg_wr(ICP_OFS_CMP1, 16'h0004);
    repeat (30) @(posedge clk_in);
    meas(hi, per);
    check(16'(hi), 16'd5);
    check(16'(per), 16'd9);
    // Level bit on, remote off: steady high
    reg_wr(ICP_OFS_CARRIER_CTRL, 16'h0001);
    wait_stb();
    rd_chk(ICP_OFS_CARRIER_CTRL, 16'h0003);
    hold_lvl(1'b1);
    reg_wr(ICP_OFS_CARRIER_CTRL, 16'h0004);
    wait_stb();
    hold_lvl(1'b0);
    prun <= 1'b0;
    reg_wr(ICP_OFS_CARRIER_CTRL, 16'h0002);
    rd_chk(ICP_OFS_CARRIER_CTRL, 16'h0000);
    complete_run();
  end

  initial begin
    #(40 * 20000);
    miscompares++;
    complete_run();
  end
endmodule : icp_timer_test
